// >>> src/acs_map.vh
// ==========================================================
// Contract
// - Sequence-mode pattern 0011 in register 41h selects single channel mode.
// - Sequencer mode comes from four sequence-mode bits in configuration register 1.
// - Eight 16-bit registers 48h-4Fh form four 32-bit per-channel vectors.
// - Sequencer steps enabled channels, applies their settings, stores results itself.
// - Selection bit one includes the channel, zero excludes it.
// - Order runs from bit 0 of 48h to bit 15 of 49h.
// - On-chip bits map to fixed channels; bits 1-4 and 15 are invalid.
// - Auxiliary bit n is converter channel 16 plus n.
// - Averaging registers 4Ah/4Bh use selection bit layout; one enables averaging.
// - Averaged result uses 16, 64 or 256 samples per averaging-amount bits.
// - With averaging, end-of-sequence pulses only after the averaging completes.
// - Plain channels update every pass; averaged ones only when average completes.
// - Calibration averaging: first update after one pass, then every 16 conversions.
// - Input-mode registers 4Ch/4Dh: one bipolar, zero unipolar by default.
// - Only dedicated pair and auxiliary pairs honour input-mode bits.
// - Internal sensor channels always convert unipolar.
// - External settling is four cycles, ten when its 4Eh/4Fh bit is set.
// ==========================================================
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ==========================================================
// Register offsets
`define ACS_ADDR_CFG0       7'h40
`define ACS_ADDR_CFG1       7'h41
`define ACS_ADDR_SEL_ON     7'h48
`define ACS_ADDR_SEL_AUX    7'h49
`define ACS_ADDR_AVG_ON     7'h4A
`define ACS_ADDR_AVG_AUX    7'h4B
`define ACS_ADDR_POL_ON     7'h4C
`define ACS_ADDR_POL_AUX    7'h4D
`define ACS_ADDR_SET_ON     7'h4E
`define ACS_ADDR_SET_AUX    7'h4F

// ==========================================================
// Reset values
`define ACS_RST_REG         16'h0000

// ==========================================================
// Field positions, configuration register 0
`define ACS_CH_HI           4
`define ACS_CH_LO           0
`define ACS_ACQ_BIT         8
`define ACS_BU_BIT          10
`define ACS_AVG_HI          13
`define ACS_AVG_LO          12
`define ACS_CALIBRATION_AVERAGING_OFF_BIT        15
// Field positions, configuration register 1
`define ACS_SEQ_HI          15
`define ACS_SEQ_LO          12

// ==========================================================
// Sequence modes
`define ACS_SEQ_DEFAULT     4'h0
`define ACS_SEQ_PASS        4'h1
`define ACS_SEQ_CONT        4'h2
`define ACS_SEQ_SINGLE      4'h3

// ==========================================================
// Channel layout
`define ACS_ONCHIP_VALID    16'h7FE1
`define ACS_DEFAULT_SEL     16'h4701
`define ACS_IDX_CAL         5'h00
`define ACS_IDX_DEDICATED   5'h0B
`define ACS_CAL_AVG_LAST    8'h0F

// ==========================================================
// Timing counts in converter clock cycles
`define ACS_SETTLE_SHORT    4'h4
`define ACS_SETTLE_LONG     4'hA

`endif

// >>> src/acs_next_chan.v
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Lowest set mask bit at or above start
module acs_next_chan (
  input  wire [31:0] mask,
  input  wire [5:0]  start_idx,
  output reg         found,
  output reg  [4:0]  idx
);
  integer i;

  always @* begin
    found = 1'b0;
    idx   = 5'h00;
    for (i = 31; i >= 0; i = i - 1) begin
      if (mask[i] && ({1'b0, i[4:0]} >= start_idx)) begin
        found = 1'b1;
        idx   = i[4:0];
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/acs_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
module acs_sequencer (
  input  wire        clock,
  input  wire        resetn,
  // Dynamic register port
  input  wire        dyn_en,
  input  wire        dyn_we,
  input  wire [6:0]  dyn_addr,
  input  wire [15:0] dyn_wdata,
  output reg  [15:0] dyn_rdata,
  output reg         dyn_ready,
  // Converter side
  input  wire        conv_done,
  input  wire [15:0] conv_data,
  output reg         conv_start,
  output reg  [4:0]  conv_channel,
  output reg         conv_bipolar,
  output reg         conv_reset,
  // Results
  output reg         result_valid,
  output reg  [4:0]  result_channel,
  output reg  [15:0] result_data,
  output reg         end_of_sequence_pulse,
  output reg         busy
);
  // ==========================================================
  // States
  localparam ST_IDLE   = 3'd0;
  localparam ST_PICK   = 3'd1;
  localparam ST_SETTLE = 3'd2;
  localparam ST_CONV   = 3'd3;
  localparam ST_STORE  = 3'd4;

  // ==========================================================
  // Registers
  reg [15:0] cfg0_reg;
  reg [15:0] cfg1_reg;
  reg [15:0] sel_on_reg;
  reg [15:0] sel_aux_reg;
  reg [15:0] avg_on_reg;
  reg [15:0] avg_aux_reg;
  reg [15:0] pol_on_reg;
  reg [15:0] pol_aux_reg;
  reg [15:0] set_on_reg;
  reg [15:0] set_aux_reg;

  reg [2:0]  state_reg;
  reg [5:0]  seq_pos_reg;
  reg [4:0]  cur_idx_reg;
  reg [3:0]  settle_reg;
  reg [15:0] sample_reg;
  reg        pass_done_reg;
  reg        pass_avg_done_reg;
  reg        cal_seen_reg;
  reg [31:0] avg_valid_reg;
  reg [23:0] acc_mem [0:31];
  reg [7:0]  cnt_mem [0:31];

  // ==========================================================
  // Decode
  wire [3:0] seq_mode = cfg1_reg[`ACS_SEQ_HI:`ACS_SEQ_LO];
  wire       mode_default = (seq_mode == `ACS_SEQ_DEFAULT);
  wire       mode_seq = mode_default || (seq_mode == `ACS_SEQ_CONT) ||
                        ((seq_mode == `ACS_SEQ_PASS) && !pass_done_reg);
  // After a single pass the block falls back to single channel
  wire       mode_single = (seq_mode == `ACS_SEQ_SINGLE) ||
                           ((seq_mode == `ACS_SEQ_PASS) && pass_done_reg);
  wire       cfg1_write = dyn_en && dyn_we && (dyn_addr == `ACS_ADDR_CFG1);

  // Default mode ignores user selection and averaging vectors and averages all by 16
  wire [31:0] sel_vec = mode_default ? {16'h0000, `ACS_DEFAULT_SEL} :
                        {sel_aux_reg, sel_on_reg & `ACS_ONCHIP_VALID};
  wire [31:0] avg_vec = mode_default ? 32'hFFFF_FFFF :
                        {avg_aux_reg, avg_on_reg};
  wire [31:0] pol_vec = {pol_aux_reg, pol_on_reg};
  wire [31:0] set_vec = {set_aux_reg, set_on_reg};
  wire [1:0]  avg_sel = mode_default ? 2'b01 : cfg0_reg[`ACS_AVG_HI:`ACS_AVG_LO];

  wire        nxt_found;
  wire [4:0]  nxt_idx;

  acs_next_chan u_next (
    .mask      (sel_vec),
    .start_idx (seq_pos_reg),
    .found     (nxt_found),
    .idx       (nxt_idx)
  );

  // ==========================================================
  // Channel map helpers
  function [4:0] idx_to_chan;
    input [4:0] idx;
    begin
      if (idx[4])
        idx_to_chan = idx;
      else if (idx == `ACS_IDX_CAL)
        idx_to_chan = 5'h08;
      else if (idx[3])
        idx_to_chan = {2'b00, idx[2:0]};
      else
        idx_to_chan = {2'b01, idx[2:0]};
    end
  endfunction

  // Dedicated pair or auxiliary pair
  function is_external;
    input [4:0] idx;
    begin
      is_external = idx[4] || (idx == `ACS_IDX_DEDICATED);
    end
  endfunction

  function is_ext_chan;
    input [4:0] ch;
    begin
      is_ext_chan = ch[4] || (ch == 5'h03);
    end
  endfunction

  // ==========================================================
  // Averaging arithmetic for the current channel
  wire        cur_is_cal = (cur_idx_reg == `ACS_IDX_CAL);
  wire        cur_avg_on = cur_is_cal ? (!cfg0_reg[`ACS_CALIBRATION_AVERAGING_OFF_BIT] || mode_default) :
                           (avg_vec[cur_idx_reg] && (avg_sel != 2'b00));
  wire [23:0] acc_now = avg_valid_reg[cur_idx_reg] ? acc_mem[cur_idx_reg] : 24'h000000;
  wire [7:0]  cnt_now = avg_valid_reg[cur_idx_reg] ? cnt_mem[cur_idx_reg] : 8'h00;
  wire [23:0] acc_sum = acc_now + {8'h00, sample_reg};
  reg  [7:0]  cnt_last;
  reg  [15:0] avg_result;

  always @* begin
    cnt_last   = 8'hFF;
    avg_result = acc_sum[23:8];
    if (cur_is_cal) begin
      cnt_last   = `ACS_CAL_AVG_LAST;
      avg_result = acc_sum[19:4];
    end else begin
      case (avg_sel)
        2'b01: begin
          cnt_last   = 8'h0F;
          avg_result = acc_sum[19:4];
        end
        2'b10: begin
          cnt_last   = 8'h3F;
          avg_result = acc_sum[21:6];
        end
        default: begin
          cnt_last   = 8'hFF;
          avg_result = acc_sum[23:8];
        end
      endcase
    end
  end

  wire avg_complete = (cnt_now == cnt_last);

  // ==========================================================
  // Register port
  always @(posedge clock) begin
    if (!resetn) begin
      cfg0_reg    <= `ACS_RST_REG;
      cfg1_reg    <= `ACS_RST_REG;
      sel_on_reg  <= `ACS_RST_REG;
      sel_aux_reg <= `ACS_RST_REG;
      avg_on_reg  <= `ACS_RST_REG;
      avg_aux_reg <= `ACS_RST_REG;
      pol_on_reg  <= `ACS_RST_REG;
      pol_aux_reg <= `ACS_RST_REG;
      set_on_reg  <= `ACS_RST_REG;
      set_aux_reg <= `ACS_RST_REG;
      dyn_rdata   <= 16'h0000;
      dyn_ready   <= 1'b0;
    end else begin
      dyn_ready <= dyn_en;
      if (dyn_en && dyn_we) begin
        case (dyn_addr)
          `ACS_ADDR_CFG0:    cfg0_reg    <= dyn_wdata;
          `ACS_ADDR_CFG1:    cfg1_reg    <= dyn_wdata;
          `ACS_ADDR_SEL_ON:  sel_on_reg  <= dyn_wdata;
          `ACS_ADDR_SEL_AUX: sel_aux_reg <= dyn_wdata;
          `ACS_ADDR_AVG_ON:  avg_on_reg  <= dyn_wdata;
          `ACS_ADDR_AVG_AUX: avg_aux_reg <= dyn_wdata;
          `ACS_ADDR_POL_ON:  pol_on_reg  <= dyn_wdata;
          `ACS_ADDR_POL_AUX: pol_aux_reg <= dyn_wdata;
          `ACS_ADDR_SET_ON:  set_on_reg  <= dyn_wdata;
          `ACS_ADDR_SET_AUX: set_aux_reg <= dyn_wdata;
          default: ;
        endcase
      end
      if (dyn_en) begin
        case (dyn_addr)
          `ACS_ADDR_CFG0:    dyn_rdata <= cfg0_reg;
          `ACS_ADDR_CFG1:    dyn_rdata <= cfg1_reg;
          `ACS_ADDR_SEL_ON:  dyn_rdata <= sel_on_reg;
          `ACS_ADDR_SEL_AUX: dyn_rdata <= sel_aux_reg;
          `ACS_ADDR_AVG_ON:  dyn_rdata <= avg_on_reg;
          `ACS_ADDR_AVG_AUX: dyn_rdata <= avg_aux_reg;
          `ACS_ADDR_POL_ON:  dyn_rdata <= pol_on_reg;
          `ACS_ADDR_POL_AUX: dyn_rdata <= pol_aux_reg;
          `ACS_ADDR_SET_ON:  dyn_rdata <= set_on_reg;
          `ACS_ADDR_SET_AUX: dyn_rdata <= set_aux_reg;
          default:           dyn_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Averaging memory, validity kept separately so a restart is one cycle
  always @(posedge clock) begin
    if (state_reg == ST_STORE && mode_seq && cur_avg_on) begin
      acc_mem[cur_idx_reg] <= acc_sum;
      cnt_mem[cur_idx_reg] <= cnt_now + 8'h01;
    end
  end

  // ==========================================================
  // Sequencer
  always @(posedge clock) begin
    if (!resetn) begin
      state_reg             <= ST_IDLE;
      seq_pos_reg           <= 6'h00;
      cur_idx_reg           <= 5'h00;
      settle_reg            <= 4'h0;
      sample_reg            <= 16'h0000;
      pass_done_reg         <= 1'b0;
      pass_avg_done_reg     <= 1'b0;
      cal_seen_reg          <= 1'b0;
      avg_valid_reg         <= 32'h0000_0000;
      conv_start            <= 1'b0;
      conv_channel          <= 5'h00;
      conv_bipolar          <= 1'b0;
      conv_reset            <= 1'b0;
      result_valid          <= 1'b0;
      result_channel        <= 5'h00;
      result_data           <= 16'h0000;
      end_of_sequence_pulse <= 1'b0;
      busy                  <= 1'b0;
    end else begin
      conv_start            <= 1'b0;
      conv_reset            <= 1'b0;
      result_valid          <= 1'b0;
      end_of_sequence_pulse <= 1'b0;
      busy                  <= (state_reg != ST_IDLE);
      if (cfg1_write) begin
        // Mode write restarts, drops averaging, keeps results
        state_reg         <= ST_IDLE;
        seq_pos_reg       <= 6'h00;
        pass_done_reg     <= 1'b0;
        pass_avg_done_reg <= 1'b0;
        cal_seen_reg      <= 1'b0;
        avg_valid_reg     <= 32'h0000_0000;
        conv_reset        <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (mode_single || mode_seq)
              state_reg <= ST_PICK;
          end
          ST_PICK: begin
            if (mode_single) begin
              conv_channel <= cfg0_reg[`ACS_CH_HI:`ACS_CH_LO];
              conv_bipolar <= cfg0_reg[`ACS_BU_BIT] &&
                              is_ext_chan(cfg0_reg[`ACS_CH_HI:`ACS_CH_LO]);
              settle_reg   <= cfg0_reg[`ACS_ACQ_BIT] ? `ACS_SETTLE_LONG :
                              `ACS_SETTLE_SHORT;
              state_reg    <= ST_SETTLE;
            end else if (!mode_seq) begin
              state_reg <= ST_IDLE;
            end else if (nxt_found) begin
              cur_idx_reg  <= nxt_idx;
              conv_channel <= idx_to_chan(nxt_idx);
              conv_bipolar <= is_external(nxt_idx) && pol_vec[nxt_idx];
              settle_reg   <= (is_external(nxt_idx) && set_vec[nxt_idx]) ?
                              `ACS_SETTLE_LONG : `ACS_SETTLE_SHORT;
              state_reg    <= ST_SETTLE;
            end else if (sel_vec != 32'h0000_0000) begin
              // End of pass
              seq_pos_reg           <= 6'h00;
              pass_avg_done_reg     <= 1'b0;
              end_of_sequence_pulse <= !(|(sel_vec & avg_vec & 32'hFFFF_FFFE)) ||
                                       (avg_sel == 2'b00) ||
                                       pass_avg_done_reg;
              if (seq_mode == `ACS_SEQ_PASS)
                pass_done_reg <= 1'b1;
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          ST_SETTLE: begin
            if (settle_reg <= 4'h1) begin
              conv_start <= 1'b1;
              state_reg  <= ST_CONV;
            end else begin
              settle_reg <= settle_reg - 4'h1;
            end
          end
          ST_CONV: begin
            if (conv_done) begin
              sample_reg <= conv_data;
              state_reg  <= ST_STORE;
            end
          end
          ST_STORE: begin
            state_reg      <= ST_PICK;
            // In sequence modes the channel moves on after every conversion, also mid-average
            if (!mode_seq) begin
              result_valid   <= 1'b1;
              result_channel <= conv_channel;
              result_data    <= sample_reg;
            end else begin
              seq_pos_reg <= {1'b0, cur_idx_reg} + 6'h01;
              if (!cur_avg_on) begin
                result_valid   <= 1'b1;
                result_channel <= conv_channel;
                result_data    <= sample_reg;
              end else if (cur_is_cal && !cal_seen_reg) begin
                // Coefficients first land after one pass
                cal_seen_reg   <= 1'b1;
                result_valid   <= 1'b1;
                result_channel <= conv_channel;
                result_data    <= sample_reg;
                avg_valid_reg[cur_idx_reg] <= 1'b0;
              end else if (avg_complete) begin
                result_valid   <= 1'b1;
                result_channel <= conv_channel;
                result_data    <= avg_result;
                avg_valid_reg[cur_idx_reg] <= 1'b0;
                if (!cur_is_cal)
                  pass_avg_done_reg <= 1'b1;
              end else begin
                avg_valid_reg[cur_idx_reg] <= 1'b1;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/acs_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Converter answering after a set delay
module acs_conv_model (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        conv_start,
  input  wire logic        conv_reset,
  input  wire logic [4:0]  conv_channel,
  input  wire logic        conv_bipolar,
  input  wire logic [3:0]  lat,
  output logic             conv_done,
  output logic [15:0]      conv_data
);
  logic [3:0]  cnt_reg;
  logic        busy_reg;
  logic [15:0] word_reg;
  always @(posedge clock) begin
    conv_done <= 1'b0;
    // Released bus toggles so stale data never looks valid
    conv_data <= ~conv_data;
    if (!resetn) begin
      busy_reg <= 1'b0;
      conv_data <= 16'h0000;
    end else if (conv_reset) begin
      busy_reg <= 1'b0;
    end else if (conv_start) begin
      busy_reg <= 1'b1;
      cnt_reg <= lat;
      word_reg <= {conv_bipolar, 2'h0, conv_channel, 8'h5A};
    end else if (busy_reg) begin
      if (cnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= word_reg;
      end else cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule
`default_nettype wire

// >>> verification/acs_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"
// ==========================================================
// Port checks
module acs_seq_checker (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        dyn_en,
  input wire logic        dyn_we,
  input wire logic [6:0]  dyn_addr,
  input wire logic [15:0] dyn_wdata,
  input wire logic [15:0] dyn_rdata,
  input wire logic        dyn_ready,
  input wire logic        conv_done,
  input wire logic [15:0] conv_data,
  input wire logic        conv_start,
  input wire logic [4:0]  conv_channel,
  input wire logic        conv_bipolar,
  input wire logic        conv_reset,
  input wire logic        result_valid,
  input wire logic [4:0]  result_channel,
  input wire logic [15:0] result_data,
  input wire logic        end_of_sequence_pulse,
  input wire logic        busy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_ready; dyn_ready == $past(dyn_en); endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after access");
  property p_rdata_hold; !dyn_ready |-> $stable(dyn_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_mode_reset;
    conv_reset == ($past(dyn_en) && $past(dyn_we) && $past(dyn_addr) == `ACS_ADDR_CFG1);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("converter reset mismatch");
  property p_settle; conv_start |-> conv_channel == $past(conv_channel, 4); endproperty
  a_settle: assert property (p_settle) else $error("channel not settled");
  property p_one_conv; conv_start |=> !conv_start [*4]; endproperty
  a_one_conv: assert property (p_one_conv) else $error("starts too close");
  property p_unipolar;
    conv_start && conv_channel != 5'h03 && conv_channel < 5'h10 |-> !conv_bipolar;
  endproperty
  a_unipolar: assert property (p_unipolar) else $error("internal channel bipolar");
  property p_valid_chan;
    conv_start |-> !(conv_channel inside {5'h07, 5'h09, 5'h0A, 5'h0B, 5'h0C});
  endproperty
  a_valid_chan: assert property (p_valid_chan) else $error("invalid channel");
  property p_result_cause; result_valid |-> $past(conv_done, 2); endproperty
  a_result_cause: assert property (p_result_cause) else $error("result without sample");
  property p_result_hold;
    !result_valid |-> $stable(result_data) && $stable(result_channel);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("status moved");
  property p_eos; end_of_sequence_pulse |=> !end_of_sequence_pulse; endproperty
  a_eos: assert property (p_eos) else $error("end pulse too long");
  property p_busy; conv_start || result_valid |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("busy low while working");
  c_eos: cover property (end_of_sequence_pulse);
  c_bip: cover property (conv_start && conv_bipolar);
  c_rst: cover property (conv_reset);
endmodule

bind acs_sequencer acs_seq_checker u_chk (.clock(clock), .resetn(resetn), .dyn_en(dyn_en),
  .dyn_we(dyn_we), .dyn_addr(dyn_addr), .dyn_wdata(dyn_wdata), .dyn_rdata(dyn_rdata),
  .dyn_ready(dyn_ready), .conv_done(conv_done), .conv_data(conv_data),
  .conv_start(conv_start), .conv_channel(conv_channel), .conv_bipolar(conv_bipolar),
  .conv_reset(conv_reset), .result_valid(result_valid), .result_channel(result_channel),
  .result_data(result_data), .end_of_sequence_pulse(end_of_sequence_pulse), .busy(busy));
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock, resetn, dyn_en, dyn_we, dyn_ready, conv_done, conv_start, conv_bipolar;
  logic        conv_reset, result_valid, end_of_sequence_pulse, busy;
  logic [6:0]  dyn_addr;
  logic [15:0] dyn_wdata, dyn_rdata, conv_data, result_data, rd, d, v [8], ex [16];
  logic [4:0]  conv_channel, result_channel, prev_ch, ch;
  logic [3:0]  lat;
  logic [31:0] s = 32'h0000001D, sel, pol, stl;
  logic [21:0] q [$], rq [$];
  int          fails, n_compared, eos_cnt, g, idx, k, p, a, n;
  bit          gv, chk_st;

  acs_sequencer uut (.clock(clock), .resetn(resetn), .dyn_en(dyn_en), .dyn_we(dyn_we),
    .dyn_addr(dyn_addr), .dyn_wdata(dyn_wdata), .dyn_rdata(dyn_rdata), .dyn_ready(dyn_ready),
    .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_bipolar(conv_bipolar), .conv_reset(conv_reset),
    .result_valid(result_valid), .result_channel(result_channel), .result_data(result_data),
    .end_of_sequence_pulse(end_of_sequence_pulse), .busy(busy));
  acs_conv_model u_conv (.clock(clock), .resetn(resetn), .conv_start(conv_start),
    .conv_reset(conv_reset), .conv_channel(conv_channel), .conv_bipolar(conv_bipolar),
    .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic ext(input logic [4:0] c);
    return c == 5'h03 || c >= 5'h10;
  endfunction
  function automatic logic [21:0] ent(input logic [4:0] c, input logic b);
    return {1'b0, c, b, 2'h0, c, 8'h5A};
  endfunction
  function automatic logic [5:0] chan_of(input int i);
    if (i >= 16 || i == 0) return i == 0 ? 6'h08 : 6'(i);
    if (i >= 5 && i <= 7) return 6'(i + 8);
    if (i >= 8 && i <= 14) return 6'(i - 8);
    return 6'h3F;
  endfunction
  // ==========================================================
  // Checking, register access, mode start
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [6:0] ad, input logic [15:0] wd,
                     output logic [15:0] rv);
    int j;
    @(posedge clock);
    dyn_en <= 1'b1;
    dyn_we <= w;
    dyn_addr <= ad;
    dyn_wdata <= wd;
    @(posedge clock);
    dyn_en <= 1'b0;
    for (j = 0; j < 4 && dyn_ready !== 1'b1; j++) @(posedge clock);
    rv = dyn_rdata;
    chk("ready", dyn_ready, 32'h1);
  endtask
  task automatic go(input logic [15:0] cfg, input logic [3:0] mode);
    acc(1'b1, 7'h41, 16'hF000, rd);
    acc(1'b1, 7'h40, cfg, rd);
    for (k = 0; k < 8; k++) acc(1'b1, 7'h48 + 7'(k), v[k], rd);
    sel = {v[1], v[0]};
    pol = {v[5], v[4]};
    stl = {v[7], v[6]};
    lat <= 4'(rnd() & 32'h7);
    acc(1'b1, 7'h41, {mode, 12'h000}, rd);
    q.delete();
    rq.delete();
    eos_cnt = 0;
  endtask
  task automatic wait_eos(input int m);
    for (k = 0; k < 20000 && eos_cnt < m; k++) @(posedge clock);
    if (eos_cnt < m) fails++;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Monitor of results, pass ends and settling gaps
  always @(posedge clock) if (resetn === 1'b1) begin
    if (result_valid === 1'b1) q.push_back({1'b0, result_channel, result_data});
    if (result_valid === 1'b1) rq.push_back({1'b0, result_channel, result_data});
    if (end_of_sequence_pulse === 1'b1) q.push_back(22'h200000);
    if (end_of_sequence_pulse === 1'b1) eos_cnt++;
    if (conv_reset === 1'b1) gv = 1'b0;
    if (conv_channel !== prev_ch) begin
      g = 1;
      gv = 1'b1;
    end else if (conv_start === 1'b1) begin
      if (gv && chk_st && ext(conv_channel))
        chk("settle", g, stl[conv_channel == 5'h03 ? 11 : conv_channel] ? 10 : 4);
      gv = 1'b0;
    end else g++;
    prev_ch = conv_channel;
  end
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    tally_and_finish();
  end
  initial begin
    {resetn, dyn_en, dyn_we, dyn_addr, dyn_wdata, gv, chk_st} = '0;
    lat = 4'h1;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    for (a = 0; a < 16; a++) begin
      acc(1'b0, 7'h40 + 7'(a), 16'h0000, rd);
      chk("reset_value", rd, 16'h0000);
    end
    acc(1'b1, 7'h41, 16'hF000, rd);
    for (a = 0; a < 16; a++) begin
      d = 16'(rnd());
      if (a == 1) d[15:12] = 4'hF;
      acc(1'b1, 7'h40 + 7'(a), d, rd);
      ex[a] = (a < 2 || a >= 8) ? d : 16'h0000;
    end
    for (a = 0; a < 16; a++) begin
      acc(1'b0, 7'h40 + 7'(a), 16'h0000, rd);
      chk("reg_readback", rd, ex[a]);
    end
    // Random sequences, invalid bits and unused averaging included
    chk_st = 1'b1;
    repeat (2) begin
      for (a = 0; a < 8; a++) v[a] = 16'(rnd());
      v[1][0] = 1'b1;
      go(16'h8000, 4'h2);
      wait_eos(2);
      idx = 0;
      for (p = 0; p < 2; p++) begin
        for (a = 0; a < 32; a++) if (sel[a] && chan_of(a) != 6'h3F) begin
          ch = 5'(chan_of(a));
          chk("seq_entry", q[idx], ent(ch, pol[a] && ext(ch)));
          idx++;
        end
        chk("pass_end", q[idx], 22'h200000);
        idx++;
      end
    end
    chk_st = 1'b0;
    // Averaged aux channel beside a plain one, all amounts
    for (a = 1; a < 4; a++) begin
      foreach (v[k]) v[k] = 16'h0000;
      v[0] = 16'h0100;
      v[1] = 16'h0002;
      v[3] = 16'h0002;
      go(16'h8000 | (16'(a) << 12), 4'h2);
      wait_eos(1);
      n = 16 << (2 * (a - 1));
      for (k = 0; k < n; k++) chk("plain_entry", q[k], ent(5'h00, 1'b0));
      chk("avg_entry", q[n], ent(5'h11, 1'b0));
      chk("avg_pass_end", q[n + 1], 22'h200000);
    end
    // Calibration averaging
    foreach (v[k]) v[k] = 16'h0000;
    v[0] = 16'h0101;
    go(16'h0000, 4'h2);
    wait_eos(17);
    idx = 0;
    for (p = 1; p < 18; p++) begin
      if (p == 1 || p == 17) begin
        chk("cal_entry", q[idx], ent(5'h08, 1'b0));
        idx++;
      end
      chk("cal_pass", q[idx], ent(5'h00, 1'b0));
      chk("cal_end", q[idx + 1], 22'h200000);
      idx += 2;
    end
    // Default mode: raw calibration first, averages of 16 at pass 16
    go(16'h0000, 4'h0);
    wait_eos(1);
    chk("dflt_cal", q[0], ent(5'h08, 1'b0));
    for (k = 0; k < 4; k++) begin
      ch = k == 3 ? 5'h06 : 5'(k);
      chk("dflt_avg", q[k + 1], ent(ch, 1'b0));
    end
    chk("dflt_end", q[5], 22'h200000);
    // Single pass falls back to the single channel of register 40h
    foreach (v[k]) v[k] = 16'h0000;
    v[0] = 16'h0100;
    v[1] = 16'h0001;
    go(16'h8011, 4'h1);
    for (k = 0; k < 20000 && q.size() < 5; k++) @(posedge clock);
    chk("pass_a", q[0], ent(5'h00, 1'b0));
    chk("pass_b", q[1], ent(5'h10, 1'b0));
    chk("pass_eos", q[2], 22'h200000);
    chk("pass_single", q[3], ent(5'h11, 1'b0));
    chk("pass_single", q[4], ent(5'h11, 1'b0));
    // Single channel mode
    for (a = 0; a < 3; a++) begin
      ch = a == 0 ? 5'h03 : a == 1 ? 5'h11 : 5'h00;
      go(16'h8400 | {7'h00, 1'(rnd()), 3'h0, ch}, 4'h3);
      for (k = 0; k < 20000 && rq.size() < 2; k++) @(posedge clock);
      chk("single_a", rq[0], ent(ch, ext(ch)));
      chk("single_b", rq[1], ent(ch, ext(ch)));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
